// file: design/dcti_pkg.sv
// Shared constants and carrier types of the dual-channel torque cutoff interlock.
package dcti_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 25_000_000; // System clock rate in hertz.
    localparam int PULSE_TOL_US = 1000;       // Input pulse tolerance, 1 ms in microseconds.
    localparam int SKEW_MAX_MS  = 200;        // Largest allowed channel skew in milliseconds.
    localparam int CNT_W        = 24;         // Width of the filter and skew counters.

    // Counter width type.
    typedef logic [CNT_W-1:0] dcti_cnt_t;

    // Least time, so this rounds up; the division is exact at this rate.
    localparam int FILT_CYC_INT = (PULSE_TOL_US * (CLK_HZ / 1000) + 999) / 1000;
    // Longest time, so this rounds down.
    localparam int SKEW_CYC_INT = SKEW_MAX_MS * (CLK_HZ / 1000);
    localparam dcti_cnt_t FILT_CYC = dcti_cnt_t'(FILT_CYC_INT);
    localparam dcti_cnt_t SKEW_CYC = dcti_cnt_t'(SKEW_CYC_INT);
    localparam dcti_cnt_t CNT_ZERO = 24'h000000;
    localparam dcti_cnt_t CNT_ONE  = 24'h000001;

    // ------------------------------------------------------------------
    // Indication select encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_NONE     = 2'h0; // No indication on a double loss.
    localparam logic [1:0] SEL_RUN_FLT  = 2'h1; // Fault if running, warning if stopped.
    localparam logic [1:0] SEL_WARN     = 2'h2; // Warning in either run state.
    localparam logic [1:0] SEL_FAULT    = 2'h3; // Fault in either run state.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {ST_STOPPED, ST_RUNNING} dcti_run_e;

    // Operator commands, each a one-cycle pulse.
    typedef struct packed {
        logic start;
        logic stop;
        logic fault_reset;
    } dcti_cmd_s;

    // Indications and power-stage enable seen by the rest of the board.
    typedef struct packed {
        logic gate_enable;
        logic running;
        logic cutoff_active;
        logic cutoff_warning;
        logic start_blocked_warning;
        logic cutoff_fault;
        logic channel_a_loss_fault;
        logic channel_b_loss_fault;
    } dcti_status_s;

    // State of one channel filter.
    typedef struct packed {
        logic      sync_a;
        logic      sync_b;
        dcti_cnt_t cnt;
        logic      level;
    } dcti_filt_s;

    // State of the interlock core.
    typedef struct packed {
        dcti_run_e    run;
        logic         cut_prev;
        dcti_cnt_t    skew_cnt;
        dcti_status_s status;
    } dcti_core_s;

endpackage

// file: design/dcti_chan_filter.sv
// Synchroniser and pulse-rejecting filter for one cutoff input channel.
module dcti_chan_filter #(
    parameter dcti_pkg::dcti_cnt_t FILT_CYC = dcti_pkg::FILT_CYC
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Raw channel, high while energised.
    input  wire logic chan_i,
    // Filtered channel level.
    output logic      level_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dcti_pkg::dcti_filt_s s_reg; // Registered filter state.
    dcti_pkg::dcti_filt_s s_next; // Next filter state.

    // The first stage feeds only the second; the counter looks at the second.
    // A disagreement must last FILT_CYC+1 cycles, so a 1 ms pulse never passes.
    always_comb begin
        s_next        = s_reg;
        s_next.sync_a = chan_i;
        s_next.sync_b = s_reg.sync_a;
        if (s_reg.sync_b == s_reg.level) begin
            s_next.cnt = dcti_pkg::CNT_ZERO; // Agreement restarts the window. R3
        end else if (s_reg.cnt == FILT_CYC) begin
            s_next.level = s_reg.sync_b; // Held long enough, accept it. R15
            s_next.cnt   = dcti_pkg::CNT_ZERO;
        end else begin
            s_next.cnt = s_reg.cnt + dcti_pkg::CNT_ONE;
        end
    end

    // Reset assumes the channels open, which is the safe side.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.level;

    // A short disagreement leaves the accepted level untouched.
    AST_FILTER_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R3
        (s_reg.sync_b != s_reg.level && s_reg.cnt != FILT_CYC) |=> $stable(s_reg.level))
        else $error("filter level changed before the pulse window ran out");

endmodule

// file: design/dcti_interlock.sv
// Interlock core: cutoff gating, indications, faults and restart control.

// What this block does
// (R1) Either channel open removes gate enable
// (R2) Partner switches both channels within 200 ms
// (R3) Pulses up to 1 ms are ignored
// (R4) Single channel loss always raises a fault
// (R5) Select setting and run state choose indications
// (R6) Select setting never alters cutoff action
// (R7) No start until channels closed, faults reset
// (R8) Reset needed only when setting raised fault
// (R9) No self restart; fresh start required
// (R10) Start during cutoff blocked with warning
// (R11) Running cutoff stops; indicate only if selected
// (R12) Cutoff overrides every other enable path
// (R13) Channel A open reports B-loss, vice versa
// (R14) Indications are plain informational status outputs
// (R15) Inputs synchronised and filtered by counter
// (R16) Mismatch beyond skew window flags fault
module dcti_interlock #(
    parameter dcti_pkg::dcti_cnt_t FILT_CYC = dcti_pkg::FILT_CYC,
    parameter dcti_pkg::dcti_cnt_t SKEW_CYC = dcti_pkg::SKEW_CYC
) (
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    // Cutoff channels, high while energised (closed).
    input  wire logic                 cutoff_channel_a_i,
    input  wire logic                 cutoff_channel_b_i,
    // Configuration.
    input  wire logic [1:0]           cutoff_indication_select_i,
    // Drive control.
    input  wire dcti_pkg::dcti_cmd_s  cmd_i,
    input  wire logic                 drive_enable_i,
    // Indications and power stage enable.
    output dcti_pkg::dcti_status_s    status_o
);

    // ------------------------------------------------------------------
    // Channel filters
    // ------------------------------------------------------------------
    logic chan_a_f; // Filtered channel A.
    logic chan_b_f; // Filtered channel B.

    dcti_chan_filter #(.FILT_CYC(FILT_CYC)) u_filt_a (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .chan_i    (cutoff_channel_a_i),
        .level_o   (chan_a_f)
    );

    dcti_chan_filter #(.FILT_CYC(FILT_CYC)) u_filt_b (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .chan_i    (cutoff_channel_b_i),
        .level_o   (chan_b_f)
    );

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    dcti_pkg::dcti_core_s s_reg;  // Registered core state.
    dcti_pkg::dcti_core_s s_next; // Next core state.

    logic cutoff;    // Any channel open.
    logic mismatch;  // Channels disagree.
    logic cut_rise;  // First cycle of a cutoff.
    logic any_fault; // Any latched fault.
    logic skew_hit;  // Mismatch has outlasted the skew window.

    assign cutoff    = !(chan_a_f && chan_b_f);
    assign mismatch  = chan_a_f ^ chan_b_f;
    assign cut_rise  = cutoff && !s_reg.cut_prev;
    assign any_fault = s_reg.status.cutoff_fault || s_reg.status.channel_a_loss_fault
                       || s_reg.status.channel_b_loss_fault;
    assign skew_hit  = mismatch && (s_reg.skew_cnt == SKEW_CYC);

    // Indication choice: 2'b10 means fault, 2'b01 means warning, zero none.
    function automatic logic [1:0] pick_ind(input logic [1:0] sel, input logic running);
        logic [1:0] ind;
        ind = 2'h0;
        if (sel == dcti_pkg::SEL_FAULT) begin
            ind = 2'h2;
        end else if (sel == dcti_pkg::SEL_WARN) begin
            ind = 2'h1;
        end else if (sel == dcti_pkg::SEL_RUN_FLT) begin
            ind = running ? 2'h2 : 2'h1;
        end
        return ind;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The clear is considered before faults are set, so a fault that lands in
    // the reset cycle survives. The select input reaches only the indication
    // bits; run state and gate enable never read it.
    always_comb begin
        logic [1:0] ind;
        ind             = pick_ind(cutoff_indication_select_i, s_reg.run == dcti_pkg::ST_RUNNING);
        s_next          = s_reg;
        s_next.cut_prev = cutoff;

        // Skew window counter, saturating at the limit.
        if (!mismatch) begin
            s_next.skew_cnt = dcti_pkg::CNT_ZERO;
        end else if (!skew_hit) begin
            s_next.skew_cnt = s_reg.skew_cnt + dcti_pkg::CNT_ONE; // R16
        end

        // Fault reset only takes effect once both channels are closed.
        if (cmd_i.fault_reset && !cutoff) begin
            s_next.status.cutoff_fault         = 1'b0; // R7
            s_next.status.channel_a_loss_fault = 1'b0;
            s_next.status.channel_b_loss_fault = 1'b0;
        end

        // A lone open channel is always a fault; the code names the other one.
        if (skew_hit) begin
            if (!chan_a_f) begin
                s_next.status.channel_b_loss_fault = 1'b1; // R4 R13
            end else begin
                s_next.status.channel_a_loss_fault = 1'b1; // R4 R13
            end
        end

        // Indication chosen by the select setting and the run state at onset.
        if (cut_rise) begin
            if (ind == 2'h2) begin
                s_next.status.cutoff_fault = 1'b1; // R5 R11 R8
            end else if (ind == 2'h1) begin
                s_next.status.cutoff_warning = 1'b1; // R5
            end
        end
        if (!cutoff) begin
            s_next.status.cutoff_warning = 1'b0;
        end

        // Start while cut off is refused with a warning until release.
        if (cmd_i.start && cutoff) begin
            s_next.status.start_blocked_warning = 1'b1; // R10
        end else if (!cutoff) begin
            s_next.status.start_blocked_warning = 1'b0;
        end

        // Run state: cutoff and faults stop it, only a start restarts it.
        case (s_reg.run)
            dcti_pkg::ST_RUNNING: begin
                if (cutoff || any_fault || cmd_i.stop) begin
                    s_next.run = dcti_pkg::ST_STOPPED; // R11 R6
                end
            end
            dcti_pkg::ST_STOPPED: begin
                if (cmd_i.start && !cutoff && !any_fault && !cmd_i.stop) begin
                    s_next.run = dcti_pkg::ST_RUNNING; // R7 R9
                end
            end
            default: begin
                s_next.run = dcti_pkg::ST_STOPPED;
            end
        endcase

        // Cutoff is the last word on the power stage enable.
        s_next.status.running       = (s_next.run == dcti_pkg::ST_RUNNING);
        s_next.status.gate_enable   = s_next.status.running && drive_enable_i
                                      && !cutoff; // R1 R12 R6
        s_next.status.cutoff_active = cutoff;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset comes up stopped with the power stage disabled.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_reg          <= '0;
            s_reg.run      <= dcti_pkg::ST_STOPPED;
            s_reg.cut_prev <= 1'b1;
            s_reg.status.cutoff_active <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Status is informational only and leaves straight from the register.
    assign status_o = s_reg.status; // R14

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_CUT_GATE_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
        cutoff |=> !status_o.gate_enable && !status_o.running)
        else $error("gate enable stayed on during cutoff");

    AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
        status_o.gate_enable |-> status_o.running && !$past(cutoff))
        else $error("gate enabled while cutoff was active");

    AST_LONE_LOSS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
        skew_hit |=> (status_o.channel_a_loss_fault || status_o.channel_b_loss_fault))
        else $error("single channel loss raised no fault");

    AST_CODE_SWAP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
        (skew_hit && !chan_a_f) |=> status_o.channel_b_loss_fault)
        else $error("open channel A did not report channel B loss");

    AST_SKEW_WAIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
        (mismatch && !skew_hit && !any_fault) |=> !status_o.channel_a_loss_fault
        && !status_o.channel_b_loss_fault)
        else $error("mismatch fault before skew window expired");

    AST_SEL_FAULT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R5
        (cut_rise && cutoff_indication_select_i == dcti_pkg::SEL_FAULT)
        |=> status_o.cutoff_fault)
        else $error("fault setting gave no cutoff fault");

    AST_RUN_IND: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
        (cut_rise && s_reg.run == dcti_pkg::ST_RUNNING
        && cutoff_indication_select_i == dcti_pkg::SEL_NONE && !any_fault)
        |=> !status_o.cutoff_fault && !status_o.cutoff_warning)
        else $error("indication raised where none was selected");

    AST_START_BLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
        (cmd_i.start && cutoff) |=> status_o.start_blocked_warning && !status_o.running)
        else $error("start during cutoff was not blocked");

    AST_FAULT_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
        any_fault |=> !status_o.running)
        else $error("drive started with a fault latched");

    AST_NO_SELF_RUN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
        (s_reg.run == dcti_pkg::ST_STOPPED && !cmd_i.start) |=> !status_o.running)
        else $error("drive restarted without a start command");

endmodule

// file: bench/dcti_switch_model.sv
// Behavioural activation switch that drives both torque cutoff channels.
module dcti_switch_model (
    // Clock.
    input  wire logic       clk_i,
    // Open request per channel, bit 1 channel A, bit 0 channel B.
    input  wire logic [1:0] open_i,
    // Channel levels, high while closed.
    output logic            chan_a_o,
    output logic            chan_b_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ---------------------------------------------------------------
    // Contact skew
    // ---------------------------------------------------------------
    logic [2:0] b_dly = 3'h0; // Delay line that lags channel B behind A.

    // Real contacts never part at once, so B trails A by three cycles,
    // well inside the allowed switching skew.
    always @(posedge clk_i) begin
        b_dly <= {b_dly[1:0], ~open_i[0]};
    end

    // Channel A follows the request at once; a request on A alone breaks
    // the pairing on purpose, which only the glitch and single-loss tests ask for.
    assign chan_a_o = ~open_i[1];
    assign chan_b_o = b_dly[2];
endmodule

// file: bench/dcti_interlock_tb.sv
// Self-checking testbench of the torque cutoff interlock.
module dcti_interlock_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    localparam dcti_pkg::dcti_cnt_t FILT = 24'h000008; // Short filter for simulation.
    localparam dcti_pkg::dcti_cnt_t SKEW = 24'h000028; // Short skew window, 40 cycles.
    localparam int SETTLE = 20; // Filter plus output lag, with margin.
    logic                   clk_i;          // System clock.
    logic                   reset_n_i;      // Synchronous reset, active low.
    logic                   drive_enable_i; // Other control path's gate request.
    logic [1:0]             sel;            // Indication select setting.
    logic [1:0]             open_req;       // Switch model open request.
    logic                   chan_a;         // Channel A level.
    logic                   chan_b;         // Channel B level.
    dcti_pkg::dcti_cmd_s    cmd;            // Operator commands.
    dcti_pkg::dcti_status_s st;             // Status seen from the block.
    int                     err_total = 0;  // Mismatch count.
    int                     n_tests = 0;    // Comparison count.
    int                     cyc = 0;        // Cycle count for the hang guard.

    dcti_switch_model u_switch (.clk_i(clk_i), .open_i(open_req),
                                .chan_a_o(chan_a), .chan_b_o(chan_b));

    dcti_interlock #(.FILT_CYC(FILT), .SKEW_CYC(SKEW)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cutoff_channel_a_i(chan_a),
        .cutoff_channel_b_i(chan_b), .cutoff_indication_select_i(sel),
        .cmd_i(cmd), .drive_enable_i(drive_enable_i), .status_o(st));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Compares one status bit and reports a difference at once.
    task automatic check(input string what, input logic exp, input logic seen);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Waits for a number of falling edges, where inputs change.
    task automatic wait_neg(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Gives one command as a one-cycle pulse.
    task automatic pulse(input dcti_pkg::dcti_cmd_s c);
        @(negedge clk_i);
        cmd = c;
        @(negedge clk_i);
        cmd = 3'h0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Reset leaves the cutoff active; closing alone must not start the motor.
    task automatic t_reset_start();
        check("cutoff_active after reset", 1'b1, st.cutoff_active);
        check("gate after reset", 1'b0, st.gate_enable);
        open_req = 2'h0;
        wait_neg(SETTLE);
        check("cutoff released", 1'b0, st.cutoff_active);
        check("no self start", 1'b0, st.running);
        pulse(3'h4);
        wait_neg(1);
        check("running after start", 1'b1, st.running);
        check("gate after start", 1'b1, st.gate_enable);
        $display("Test reset_start done");
    endtask

    // A dip of FILT cycles stays one short of the accepted length.
    task automatic t_glitch();
        open_req = 2'h2;
        wait_neg(8);
        open_req = 2'h0;
        wait_neg(SETTLE);
        check("glitch keeps running", 1'b1, st.running);
        check("glitch filtered", 1'b0, st.cutoff_active);
        $display("Test glitch done");
    endtask

    // The other path may drop the gate and raise it again while both channels are closed.
    task automatic t_override();
        drive_enable_i = 1'b0;
        wait_neg(3);
        check("gate follows other path", 1'b0, st.gate_enable);
        drive_enable_i = 1'b1;
        wait_neg(3);
        check("gate back", 1'b1, st.gate_enable);
        $display("Test override done");
    endtask

    // Double loss in one select mode and run state, then the restart path.
    task automatic t_mode(input logic [1:0] s, input logic run);
        logic wf;
        logic ww;
        wf = (s == 2'h3) || (s == 2'h1 && run);
        ww = (s == 2'h2) || (s == 2'h1 && !run);
        sel = s;
        if (!run) pulse(3'h2);
        open_req = 2'h3;
        wait_neg(SETTLE);
        check("gate off in cutoff", 1'b0, st.gate_enable);
        check("motor stopped", 1'b0, st.running);
        check("fault per setting", wf, st.cutoff_fault);
        check("warning per setting", ww, st.cutoff_warning);
        check("no loss fault", 1'b0, st.channel_a_loss_fault | st.channel_b_loss_fault);
        pulse(3'h4);
        wait_neg(1);
        check("start blocked warning", 1'b1, st.start_blocked_warning);
        check("blocked start", 1'b0, st.running);
        open_req = 2'h0;
        wait_neg(SETTLE);
        // Both warnings are levels that last only while the cutoff does.
        check("cutoff warning cleared", 1'b0, st.cutoff_warning);
        check("blocked warning cleared", 1'b0, st.start_blocked_warning);
        pulse(3'h4);
        wait_neg(1);
        check("start needs reset", ~wf, st.running);
        pulse(3'h1);
        pulse(3'h4);
        wait_neg(1);
        check("fault cleared", 1'b0, st.cutoff_fault);
        check("gate back on", 1'b1, st.gate_enable);
        $display("Test mode %0d run %0d done", s, run);
    endtask

    // One channel lost past the skew window names the other channel.
    task automatic t_single(input logic [1:0] o);
        open_req = o;
        // Halfway through, the mismatch is still inside the skew window.
        wait_neg(40);
        check("early loss", 1'b0, st.channel_a_loss_fault | st.channel_b_loss_fault);
        wait_neg(40);
        check("single loss gate off", 1'b0, st.gate_enable);
        pulse(3'h1);
        wait_neg(1);
        check("b loss fault", o[1], st.channel_b_loss_fault);
        check("a loss fault", o[0], st.channel_a_loss_fault);
        open_req = 2'h0;
        wait_neg(SETTLE);
        pulse(3'h1);
        pulse(3'h4);
        wait_neg(1);
        check("loss cleared", 1'b0, st.channel_a_loss_fault | st.channel_b_loss_fault);
        check("restart after loss", 1'b1, st.running);
        $display("Test single loss %0d done", o);
    endtask

    // ---------------------------------------------------------------
    // Clock, hang guard and main sequence
    // ---------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // The whole run needs about 700 cycles; near thirty times that means a hang.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        reset_n_i = 1'b0;
        drive_enable_i = 1'b1;
        sel = 2'h0;
        open_req = 2'h3;
        cmd = 3'h0;
        wait_neg(3);
        reset_n_i = 1'b1;
        wait_neg(1);
        t_reset_start();
        t_glitch();
        t_override();
        for (int i = 0; i < 8; i++) begin
            t_mode(i[2:1], i[0]);
        end
        t_single(2'h2);
        t_single(2'h1);
        complete_run();
    end
endmodule
